// ==== smc_pkg.sv ====
package smc_pkg;
   // ==========================================================
   // sizes
   localparam int ADDR_W = 14;
   localparam int DATA_W = 16;
   // ==========================================================
   // timing figures, in ns, and their cycle counts at 20 MHz
   localparam int CLK_NS     = 50;
   localparam int T_ACC_NS   = 35;   // address and select access, slow grade
   localparam int T_OE_NS    = 15;   // output enable to valid
   localparam int T_WP_NS    = 30;   // store strobe width
   localparam int T_DW_NS    = 20;   // data overlap before strobe rise
   localparam int T_CHZ_NS   = 20;   // deselect to float
   localparam int T_OHZ_NS   = 10;   // output drive off to float
   localparam int T_WC_NS    = 35;   // write cycle time
   // least times round up, at least one cycle
   localparam int RD_CYC_I  = (((T_ACC_NS > T_OE_NS) ? T_ACC_NS : T_OE_NS) + CLK_NS - 1) / CLK_NS;
   localparam int WP_CYC_I  = (((T_WP_NS > T_DW_NS) ? T_WP_NS : T_DW_NS) + CLK_NS - 1) / CLK_NS;
   localparam int HZ_CYC_I  = (((T_CHZ_NS > T_OHZ_NS) ? T_CHZ_NS : T_OHZ_NS) + CLK_NS - 1)
                              / CLK_NS;
   localparam int WC_CYC_I  = (T_WC_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] RD_CYC = 4'(RD_CYC_I + 2);  // one more cycle per sync flop
   localparam logic [3:0] WP_CYC = 4'(WP_CYC_I);
   localparam logic [3:0] HZ_CYC = 4'(HZ_CYC_I);
   localparam logic [3:0] WC_CYC = 4'(WC_CYC_I);
   localparam logic [3:0] CNT_ONE = 4'h1;
   // ==========================================================
   typedef enum logic [2:0] {
      SMC_IDLE, SMC_RD, SMC_WSET, SMC_WPULSE, SMC_WREC, SMC_RREC
   } smc_state_e;
endpackage

// ==== smc_host.sv ====
`timescale 1ns/1ns
module smc_host
   import smc_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      nrst,
   input  wire logic                      req_valid,
   output logic                           req_ready,
   input  wire logic                      req_write,
   input  wire logic [smc_pkg::ADDR_W-1:0] req_addr,
   input  wire logic [smc_pkg::DATA_W-1:0] req_wdata,
   output logic                           rsp_valid,
   output logic      [smc_pkg::DATA_W-1:0] rsp_rdata,
   output logic      [smc_pkg::ADDR_W-1:0] word_index_lines,
   output logic                           sel_n,
   output logic                           out_drive_n,
   output logic                           store_n,
   input  wire logic [smc_pkg::DATA_W-1:0] bidir_word_lines_i,
   output logic      [smc_pkg::DATA_W-1:0] bidir_word_lines_o,
   output logic                           bidir_word_lines_oe
);
   import smc_pkg::*;

   // ==========================================================
   // pin input synchroniser
   logic [DATA_W-1:0] dq_s1_r;
   logic [DATA_W-1:0] dq_s2_r;

   always_ff @(posedge clk) begin
      dq_s1_r <= bidir_word_lines_i;
      dq_s2_r <= dq_s1_r;
   end

   // ==========================================================
   // access sequencer
   smc_state_e        st_r, st_nxt;
   logic [3:0]        cnt_r, cnt_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [DATA_W-1:0] wd_r, wd_nxt;
   logic [DATA_W-1:0] rd_r, rd_nxt;
   logic              sel_n_r, sel_n_nxt;
   logic              oe_n_r, oe_n_nxt;
   logic              we_n_r, we_n_nxt;
   logic              drv_r, drv_nxt;
   logic              rv_r, rv_nxt;

   assign req_ready = (st_r == SMC_IDLE);  // one access at a time

   // controls are registered; the strobe falls one edge before select, other controls may change together
   always_comb begin
      st_nxt    = st_r;
      cnt_nxt   = cnt_r;
      addr_nxt  = addr_r;
      wd_nxt    = wd_r;
      rd_nxt    = rd_r;
      sel_n_nxt = sel_n_r;
      oe_n_nxt  = oe_n_r;
      we_n_nxt  = we_n_r;
      drv_nxt   = drv_r;
      rv_nxt    = 1'b0;
      case (st_r)
         SMC_IDLE: begin
            sel_n_nxt = 1'b1;  // parked deselected
            oe_n_nxt  = 1'b1;
            we_n_nxt  = 1'b1;
            drv_nxt   = 1'b0;
            if (req_valid) begin
               addr_nxt = req_addr;  // index settles at the take edge, with select fall on reads
               wd_nxt   = req_wdata;
               if (req_write) begin
                  // drive stays high, strobe then select: module floats
                  we_n_nxt = 1'b0;
                  drv_nxt  = 1'b1;     // safe, module outputs are off
                  st_nxt   = SMC_WSET;
               end else begin
                  sel_n_nxt = 1'b0;    // strobe high, select and drive low
                  oe_n_nxt  = 1'b0;
                  cnt_nxt   = RD_CYC;
                  st_nxt    = SMC_RD;
               end
            end
         end
         SMC_RD: begin
            if (cnt_r == CNT_ONE) begin
               rd_nxt    = dq_s2_r;  // word sampled once access time passed
               rv_nxt    = 1'b1;
               sel_n_nxt = 1'b1;
               oe_n_nxt  = 1'b1;
               cnt_nxt   = HZ_CYC;
               st_nxt    = SMC_RREC;
            end else begin
               cnt_nxt = cnt_r - CNT_ONE;
            end
         end
         SMC_RREC: begin
            // module still floating its drivers
            if (cnt_r == CNT_ONE) begin
               st_nxt = SMC_IDLE;
            end else begin
               cnt_nxt = cnt_r - CNT_ONE;
            end
         end
         SMC_WSET: begin
            sel_n_nxt = 1'b0;  // overlap opens the store window
            cnt_nxt   = WP_CYC;
            st_nxt    = SMC_WPULSE;
         end
         SMC_WPULSE: begin
            if (cnt_r == CNT_ONE) begin
               we_n_nxt  = 1'b1;  // strobe rises with select, ends write
               sel_n_nxt = 1'b1;  // select up with data still held
               cnt_nxt   = WC_CYC;
               st_nxt    = SMC_WREC;
            end else begin
               cnt_nxt = cnt_r - CNT_ONE;
            end
         end
         SMC_WREC: begin
            drv_nxt = 1'b0;  // data held past the write end, hold time zero
            if (cnt_r == CNT_ONE) begin
               st_nxt = SMC_IDLE;  // recovery counted from first rise
            end else begin
               cnt_nxt = cnt_r - CNT_ONE;
            end
         end
         default: begin
            st_nxt = SMC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_r    <= SMC_IDLE;
         cnt_r   <= 4'h0;
         addr_r  <= '0;
         wd_r    <= '0;
         rd_r    <= '0;
         sel_n_r <= 1'b1;
         oe_n_r  <= 1'b1;
         we_n_r  <= 1'b1;
         drv_r   <= 1'b0;
         rv_r    <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         cnt_r   <= cnt_nxt;
         addr_r  <= addr_nxt;
         wd_r    <= wd_nxt;
         rd_r    <= rd_nxt;
         sel_n_r <= sel_n_nxt;
         oe_n_r  <= oe_n_nxt;
         we_n_r  <= we_n_nxt;
         drv_r   <= drv_nxt;
         rv_r    <= rv_nxt;
      end
   end

   // ==========================================================
   // pin outputs, all registered
   assign word_index_lines    = addr_r;
   assign sel_n               = sel_n_r;
   assign out_drive_n         = oe_n_r;
   assign store_n             = we_n_r;
   assign bidir_word_lines_o  = wd_r;
   assign bidir_word_lines_oe = drv_r;
   assign rsp_valid           = rv_r;
   assign rsp_rdata           = rd_r;

   // ==========================================================
   // checks
   sequence s_wr_open;
      !store_n && sel_n ##1 !store_n && !sel_n;
   endsequence

   AST_NO_CLASH: assert property (@(posedge clk) disable iff (!nrst)
      bidir_word_lines_oe |-> out_drive_n)
      else $error("host drives data while module output could be on");
   AST_DESEL_IDLE: assert property (@(posedge clk) disable iff (!nrst)
      req_ready && !$past(req_valid) |-> sel_n)
      else $error("select low while idle");
   AST_READ_LEVELS: assert property (@(posedge clk) disable iff (!nrst)
      !sel_n && !out_drive_n |-> store_n && !bidir_word_lines_oe)
      else $error("read levels wrong");
   AST_STROBE_FIRST: assert property (@(posedge clk) disable iff (!nrst)
      $fell(sel_n) && !out_drive_n |-> store_n)
      else $error("bad select fall");
   AST_WR_WINDOW: assert property (@(posedge clk) disable iff (!nrst)
      s_wr_open |-> (!sel_n && !store_n)[*1] ##1 store_n && sel_n)
      else $error("store window length wrong");
   AST_DATA_HELD: assert property (@(posedge clk) disable iff (!nrst)
      $rose(store_n) |-> bidir_word_lines_oe && $stable(bidir_word_lines_o))
      else $error("data dropped before write end");
   AST_READ_LEN: assert property (@(posedge clk) disable iff (!nrst)
      $fell(sel_n) && store_n |-> (!sel_n)[*3] ##1 sel_n && rsp_valid)
      else $error("read length wrong");
   AST_ONE_ACCESS: assert property (@(posedge clk) disable iff (!nrst)
      rsp_valid |-> !req_ready)
      else $error("response overlapped new access");

   // writes always run with drive high, so the module never turns on mid store
   AST_WR_DRIVE_OFF: assert property (@(posedge clk) disable iff (!nrst)
      !store_n |-> out_drive_n && bidir_word_lines_oe)
      else $error("drive low or data released during store");
   AST_SEL_AFTER_STROBE: assert property (@(posedge clk) disable iff (!nrst)
      $fell(sel_n) && !store_n |-> !$past(store_n))
      else $error("select fell before the store strobe");
   AST_RSP_PULSE: assert property (@(posedge clk) disable iff (!nrst)
      rsp_valid |=> !rsp_valid)
      else $error("response held longer than one cycle");
endmodule // smc_host

// ==== smc_ram_model.sv ====
`timescale 1ns/1ns
module smc_ram_model
   import smc_pkg::*;
(
   input  wire logic [smc_pkg::ADDR_W-1:0] word_index_lines,
   input  wire logic                       sel_n,
   input  wire logic                       out_drive_n,
   input  wire logic                       store_n,
   input  wire logic [smc_pkg::DATA_W-1:0] wr_data,
   output logic      [smc_pkg::DATA_W-1:0] rd_data,
   output logic                            rd_oe
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] last_q = '0;
   // ==========================================================
   // storage follows the control, index and data levels, no clock
   always @(sel_n, store_n, word_index_lines, wr_data) begin
      if (!sel_n && !store_n) begin
         mem[word_index_lines] = wr_data;
      end
   end
   // ==========================================================
   // drive only on a read; a low strobe keeps the lines floating
   assign rd_oe = !sel_n && !out_drive_n && store_n;
   always @* begin
      if (rd_oe) begin
         last_q = mem[word_index_lines];
      end
   end
   // released lines show the inverse, never a stale copy
   assign rd_data = rd_oe ? last_q : ~last_q;
endmodule // smc_ram_model

// ==== static_ram_module_16k_x16_bench.sv ====
`timescale 1ns/1ns
module static_ram_module_16k_x16_bench;
   import smc_pkg::*;
   logic              clk, nrst, req_valid, req_write, req_ready, rsp_valid;
   logic              sel_n, out_drive_n, store_n, host_oe, ram_oe;
   logic [ADDR_W-1:0] req_addr, word_index_lines;
   logic [DATA_W-1:0] req_wdata, rsp_rdata, host_q, ram_q, bus;
   int                err_total, checks_done;
   // ==========================================================
   // wire level: host drives when enabled, else the module lines
   assign bus = host_oe ? host_q : ram_q;
   always #25 clk = ~clk;
   smc_host dut (.clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .word_index_lines(word_index_lines),
      .sel_n(sel_n), .out_drive_n(out_drive_n), .store_n(store_n),
      .bidir_word_lines_i(bus), .bidir_word_lines_o(host_q), .bidir_word_lines_oe(host_oe));
   smc_ram_model ram (.word_index_lines(word_index_lines), .sel_n(sel_n),
      .out_drive_n(out_drive_n), .store_n(store_n), .wr_data(bus), .rd_data(ram_q),
      .rd_oe(ram_oe));
   // ==========================================================
   task automatic bad(input string m);
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // called at a rising edge; returns one edge after the take, or one edge after the answer on a read
   task automatic issue(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic [DATA_W-1:0] exp_q);
      int n;
      req_valid <= 1'b1;
      req_write <= w;
      req_addr  <= a;
      req_wdata <= d;
      n = 0;
      @(negedge clk);
      while (req_ready !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      if (req_ready !== 1'b1) begin
         bad("ready never rose");
         conclude();
      end
      @(posedge clk);
      req_valid <= 1'b0;
      if (!w) begin
         for (n = 1; n < 9; n++) begin
            @(negedge clk);
            if (rsp_valid === 1'b1) break;
         end
         checks_done += 2;
         if (n != int'(RD_CYC) + 1) bad("read answer late or early");
         if (rsp_rdata !== exp_q) bad("read word differs");
      end
      @(posedge clk);
   endtask
   // ==========================================================
   // both ends never drive at once; idle host keeps select high
   always @(negedge clk) begin
      if (nrst) begin
         checks_done += 2;
         if (host_oe === 1'b1 && ram_oe === 1'b1) bad("data line contention");
         if (req_ready === 1'b1 && sel_n !== 1'b1) bad("select low while idle");
      end
   end
   // ==========================================================
   logic [ADDR_W-1:0] at [4] = '{14'h0000, 14'h3FFF, 14'h1555, 14'h2AAA};
   logic [DATA_W-1:0] dv [4] = '{16'hFFFF, 16'h0001, 16'hA5A5, 16'h5A5A};
   task automatic check_reset();
      @(negedge clk);
      checks_done++;
      if ({sel_n, out_drive_n, store_n, host_oe, req_ready} !== 5'h1D) bad("reset levels");
      @(posedge clk);
   endtask
   // corner indices, written back to back then read back
   task automatic check_edges();
      for (int i = 0; i < 4; i++) issue(1'b1, at[i], dv[i], '0);
      for (int i = 0; i < 4; i++) issue(1'b0, at[i], '0, dv[i]);
   endtask
   // latest store wins and leaves its neighbour alone
   task automatic check_overwrite();
      issue(1'b1, 14'h3FFF, 16'h8000, '0);
      issue(1'b0, 14'h3FFF, '0, 16'h8000);
      issue(1'b0, 14'h0000, '0, 16'hFFFF);
   endtask
   initial begin
      clk       = 1'b0;
      nrst      = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr  = '0;
      req_wdata = '0;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      check_reset();
      check_edges();
      check_overwrite();
      conclude();
   end
endmodule // static_ram_module_16k_x16_bench
